//--- dlmux_pkg.sv
package dlmux_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NCONN         = 4;    // link procedure instances
  localparam int CONN_W        = 2;    // connection index width
  localparam int SAPI_W        = 6;    // access point identifier width
  localparam int TEI_W         = 7;    // terminal endpoint identifier width
  localparam int LEN_W         = 9;    // receive octet counter width
  localparam int RX_MAX_OCTETS = 264;  // largest frame held between flags
  ////////////////////////////////////////////////////////////////////////////
  // line coding
  localparam logic [7:0]  FLAG_PATTERN = 8'h7e;  // sent bit 0 first
  localparam logic [2:0]  STUFF_RUN    = 3'h5;   // ones before a stuffed zero
  localparam logic [2:0]  FLAG_RUN     = 3'h6;   // ones inside a flag
  localparam logic [2:0]  ABORT_RUN    = 3'h7;   // ones that abort a frame
  localparam logic [2:0]  PIPE_DEPTH   = 3'h6;   // flag bits held back from data
  localparam logic [2:0]  LAST_BIT     = 3'h7;   // last bit index of an octet
  ////////////////////////////////////////////////////////////////////////////
  // check sequence, lsb-first register form
  localparam logic [15:0] FCS_PRESET       = 16'hffff;
  localparam logic [15:0] FCS_POLY_REFL    = 16'h8408;  // x16+x12+x5+1
  localparam logic [15:0] FCS_GOOD_RESIDUE = 16'hf0b8;  // 0001 1101 0000 1111
  localparam logic [3:0]  FCS_LAST_BIT     = 4'hf;
  localparam logic [LEN_W-1:0] FCS_OCTETS    = 9'h002;
  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam logic [LEN_W-1:0] MIN_OCT_SEQ   = 9'h006;  // with sequence numbers
  localparam logic [LEN_W-1:0] MIN_OCT_NOSEQ = 9'h005;  // without
  localparam logic [1:0]  CTRL_UNNUMBERED   = 2'h3;     // control bits 1:0
  localparam logic [SAPI_W-1:0] SAPI_PRIORITY = 6'h00;  // wins arbitration
  ////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_DELIVER} rx_state_t;
  typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_FCS} tx_state_t;
  ////////////////////////////////////////////////////////////////////////////
  // one serial step of the check register
  function automatic logic [15:0] fcs_step(input logic [15:0] crc, input logic d);
    fcs_step = (crc >> 1) ^ ((crc[0] ^ d) ? FCS_POLY_REFL : 16'h0000);
  endfunction
endpackage

//--- dchannel_frame_multiplexer.sv
module dchannel_frame_multiplexer
  import dlmux_pkg::*;
(
  input  wire logic                                mclk,          // bit-side clock
  input  wire logic                                srst,          // sync reset
  input  wire logic                                rx_bit,        // received line bit
  input  wire logic                                rx_bit_valid,  // rx_bit strobe
  input  wire logic                                tx_bit_ready,  // phy wants next bit
  output logic                                     tx_bit,        // transmitted line bit
  output logic                                     ph_activate_req, // channel wanted
  input  wire logic [dlmux_pkg::NCONN-1:0]         conn_active,   // connection needs service
  input  wire logic [dlmux_pkg::NCONN-1:0][dlmux_pkg::SAPI_W-1:0] conn_sapi,
  input  wire logic [dlmux_pkg::NCONN-1:0][dlmux_pkg::TEI_W-1:0]  conn_tei,
  output logic [7:0]                               rx_data,       // delivered octet
  output logic                                     rx_valid,      // rx_data strobe
  output logic                                     rx_first,      // first octet of frame
  output logic                                     rx_last,       // last octet of frame
  output logic [dlmux_pkg::CONN_W-1:0]             rx_conn,       // target connection
  input  wire logic [dlmux_pkg::NCONN-1:0]         tx_req,        // frame pending
  input  wire logic [dlmux_pkg::NCONN-1:0][7:0]    tx_octet,      // next octet to send
  input  wire logic [dlmux_pkg::NCONN-1:0]         tx_octet_last, // octet ends frame
  output logic [dlmux_pkg::NCONN-1:0]              tx_take,       // octet consumed
  output logic [dlmux_pkg::NCONN-1:0]              tx_grant       // owns the line
);
  import dlmux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    rx_state_t              rs;     // receive phase
    logic [2:0]             rones;  // received ones run
    logic [5:0]             pipe;   // data bits held back
    logic [2:0]             pcnt;   // pipe fill
    logic [7:0]             rsh;    // octet assembly
    logic [2:0]             rbit;   // bit within octet
    logic [LEN_W-1:0]       rlen;   // octets stored
    logic                   rover;  // frame too long or aborted
    logic [15:0]            rcrc;   // receive check register
    logic [LEN_W-1:0]       rrd;    // delivery index
    logic [LEN_W-1:0]       rend;   // octets to deliver
    logic [CONN_W-1:0]      rsel;   // matched connection
    logic                   rv;     // delivery strobe
    logic                   rf;     // first marker
    logic                   rl;     // last marker
    logic [CONN_W-1:0]      rc;     // delivered connection
    tx_state_t              ts;     // transmit phase
    logic [7:0]             tsh;    // octet being sent
    logic [3:0]             tbit;   // bit within octet or check
    logic [2:0]             tones;  // sent ones run
    logic [15:0]            tcrc;   // transmit check register
    logic [CONN_W-1:0]      tsel;   // granted connection
    logic                   tlast;  // current octet ends frame
    logic                   tb;     // line bit
    logic [NCONN-1:0]       take;   // consume pulse
    logic [NCONN-1:0]       grant;  // line owner
    logic                   act;    // activation request
  } state_t;

  state_t s;       // registered state
  state_t next_s;  // next state

  logic [7:0] mem [RX_MAX_OCTETS];  // frame store, checked before delivery
  logic                   wr_en;    // store an octet
  logic [LEN_W-1:0]       wr_addr;  // where
  logic [7:0]             wr_data;  // what
  logic [NCONN-1:0]       hit;      // connection identifier match

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: priority access point first, then lowest index
  function automatic logic [CONN_W:0] pick(input logic [NCONN-1:0] req,
                                           input logic [NCONN-1:0][SAPI_W-1:0] sapi);
    logic [CONN_W:0] r;
    r = '0;
    // lower index replaces, unless it is not priority and would displace a priority winner
    for (int i = NCONN - 1; i >= 0; i--) begin
      if (req[i] && (!r[CONN_W] || sapi[i] == SAPI_PRIORITY ||
                     sapi[r[CONN_W-1:0]] != SAPI_PRIORITY))
        r = {1'b1, CONN_W'(i)};
    end
    pick = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address match per connection, stored octets 0 and 1
  genvar g;
  generate
    for (g = 0; g < NCONN; g++) begin : g_match
      assign hit[g] = (mem[0][7:2] == conn_sapi[g]) && (mem[1][7:1] == conn_tei[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic             d;       // destuffed bit
    logic             push;    // d is frame content
    logic             isflag;  // flag seen
    logic             ok;      // frame valid
    logic [CONN_W:0]  w;       // arbitration result
    logic [CONN_W:0]  m;       // first matching connection
    logic [7:0]       nsh;     // assembled octet
    logic [LEN_W-1:0] minlen;  // least legal length
    d = 1'b0;
    push = 1'b0;
    isflag = 1'b0;
    ok = 1'b0;
    w = pick(tx_req, conn_sapi);
    m = '0;
    nsh = '0;
    minlen = MIN_OCT_SEQ;
    next_s = s;
    wr_en = 1'b0;
    wr_addr = s.rlen;
    wr_data = '0;
    next_s.rv = 1'b0;
    next_s.rf = 1'b0;  // markers are pulses, like the strobe
    next_s.rl = 1'b0;
    next_s.take = '0;
    // activation while anything needs the channel
    next_s.act = (|conn_active) || (|tx_req) || (s.ts != TX_FLAG);

    // receive: run counting, destuffing, flag and abort detection
    if (rx_bit_valid) begin
      if (rx_bit) begin
        if (s.rones >= FLAG_RUN) begin
          next_s.rones = ABORT_RUN;
          next_s.rover = 1'b1;  // voids a frame assembled during delivery
          if (s.rs == RX_FRAME)
            next_s.rs = RX_HUNT;
        end else begin
          next_s.rones = s.rones + 3'h1;
          push = (s.rones < STUFF_RUN);
          d = 1'b1;
        end
      end else begin
        next_s.rones = '0;
        // zero after six ones closes a flag
        if (s.rones == FLAG_RUN)
          isflag = 1'b1;
        else if (s.rones != STUFF_RUN && s.rones != ABORT_RUN)
          push = 1'b1;
      end
    end

    // content bits pass a pipe so the flag's own bits never reach the check
    // assembly goes on during delivery, behind a shared flag
    if (push && s.rs != RX_HUNT) begin
      next_s.pipe = {d, s.pipe[5:1]};
      if (s.pcnt != PIPE_DEPTH) begin
        next_s.pcnt = s.pcnt + 3'h1;
      end else begin
        // check register runs over address to check sequence
        next_s.rcrc = fcs_step(s.rcrc, s.pipe[0]);
        nsh = {s.pipe[0], s.rsh[7:1]};
        next_s.rsh = nsh;
        next_s.rbit = s.rbit + 3'h1;
        if (s.rbit == LAST_BIT) begin
          if (s.rlen == LEN_W'(RX_MAX_OCTETS)) begin
            next_s.rover = 1'b1;
          end else begin
            wr_en = 1'b1;
            wr_data = nsh;
            next_s.rlen = s.rlen + 9'h001;
          end
        end
      end
    end

    // flag handling
    if (isflag) begin
      // unnumbered frames have one control octet, others two
      if (mem[2][1:0] == CTRL_UNNUMBERED)
        minlen = MIN_OCT_NOSEQ;
      for (int i = NCONN - 1; i >= 0; i--) begin
        if (hit[i])
          m = {1'b1, CONN_W'(i)};
      end
      // two-octet address only, single octet dropped
      // information field optional, no upper bound beyond store
      ok = (s.rbit == '0) && !s.rover && (s.rlen >= minlen) &&
           (s.rcrc == FCS_GOOD_RESIDUE) && !mem[0][0] && mem[1][0] && m[CONN_W];
      if (s.rs == RX_FRAME && ok) begin
        next_s.rs = RX_DELIVER;
        next_s.rend = s.rlen - FCS_OCTETS;
        next_s.rrd = '0;
        next_s.rsel = m[CONN_W-1:0];
      end else if (s.rs != RX_DELIVER) begin
        // this flag opens the next frame
        next_s.rs = RX_FRAME;
      end
      // every flag restarts assembly; a frame closing mid-delivery is lost
      next_s.pcnt = '0;
      next_s.rbit = '0;
      next_s.rlen = '0;
      next_s.rover = 1'b0;
      next_s.rcrc = FCS_PRESET;
    end

    // delivery of a checked frame, one octet per clock
    if (s.rs == RX_DELIVER) begin
      next_s.rv = 1'b1;
      next_s.rf = (s.rrd == '0);
      next_s.rl = (s.rrd == s.rend - 9'h001);
      next_s.rc = s.rsel;
      next_s.rrd = s.rrd + 9'h001;
      // closing flag has already opened the next frame
      if (s.rrd == s.rend - 9'h001)
        next_s.rs = RX_FRAME;
    end

    // transmit, one bit per phy request
    if (tx_bit_ready) begin
      if (s.tones == STUFF_RUN) begin
        // inserted zero, also after the check sequence
        next_s.tb = 1'b0;
        next_s.tones = '0;
      end else begin
        case (s.ts)
          TX_FLAG: begin
            next_s.tb = FLAG_PATTERN[s.tbit[2:0]];
            next_s.tones = '0;
            next_s.tbit = s.tbit + 4'h1;
            next_s.grant = '0;
            if (s.tbit[2:0] == LAST_BIT) begin
              next_s.tbit = '0;
              // winner owns the line for a whole frame
              if (w[CONN_W]) begin
                next_s.ts = TX_DATA;
                next_s.tsel = w[CONN_W-1:0];
                next_s.tsh = tx_octet[w[CONN_W-1:0]];
                next_s.tlast = tx_octet_last[w[CONN_W-1:0]];
                next_s.take[w[CONN_W-1:0]] = 1'b1;
                next_s.grant[w[CONN_W-1:0]] = 1'b1;
                next_s.tcrc = FCS_PRESET;
              end
            end
          end
          TX_DATA: begin
            next_s.tb = s.tsh[0];
            next_s.tones = s.tsh[0] ? s.tones + 3'h1 : 3'h0;
            next_s.tcrc = fcs_step(s.tcrc, s.tsh[0]);
            next_s.tsh = {1'b0, s.tsh[7:1]};
            next_s.tbit = s.tbit + 4'h1;
            if (s.tbit[2:0] == LAST_BIT) begin
              next_s.tbit = '0;
              if (s.tlast) begin
                next_s.ts = TX_FCS;
              end else begin
                next_s.tsh = tx_octet[s.tsel];
                next_s.tlast = tx_octet_last[s.tsel];
                next_s.take[s.tsel] = 1'b1;
              end
            end
          end
          default: begin
            // complement sent, low bit first; flag follows
            next_s.tb = ~s.tcrc[0];
            next_s.tones = ~s.tcrc[0] ? s.tones + 3'h1 : 3'h0;
            next_s.tcrc = {1'b0, s.tcrc[15:1]};
            next_s.tbit = s.tbit + 4'h1;
            if (s.tbit == FCS_LAST_BIT) begin
              next_s.tbit = '0;
              next_s.ts = TX_FLAG;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.rs <= RX_HUNT;
      s.ts <= TX_FLAG;
      s.rcrc <= FCS_PRESET;
      s.tcrc <= FCS_PRESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame store and delivered octet
  always_ff @(posedge mclk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (srst)
      rx_data <= '0;
    else if (s.rs == RX_DELIVER)
      rx_data <= mem[s.rrd];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign tx_bit          = s.tb;
  assign ph_activate_req = s.act;
  assign rx_valid        = s.rv;
  assign rx_first        = s.rf;
  assign rx_last         = s.rl;
  assign rx_conn         = s.rc;
  assign tx_take         = s.take;
  assign tx_grant        = s.grant;
endmodule

//--- dchannel_frame_multiplexer_monitor.sv
module dchannel_frame_multiplexer_monitor
  import dlmux_pkg::*;
(
  input wire logic                                  mclk,
  input wire logic                                  srst,
  input wire logic                                  tx_bit,
  input wire logic                                  tx_bit_ready,
  input wire logic                                  ph_activate_req,
  input wire logic [NCONN-1:0]                      conn_active,
  input wire logic [NCONN-1:0][SAPI_W-1:0]          conn_sapi,
  input wire logic [NCONN-1:0][TEI_W-1:0]           conn_tei,
  input wire logic [7:0]                            rx_data,
  input wire logic                                  rx_valid,
  input wire logic                                  rx_first,
  input wire logic                                  rx_last,
  input wire logic [CONN_W-1:0]                     rx_conn,
  input wire logic [NCONN-1:0]                      tx_req,
  input wire logic [NCONN-1:0]                      tx_take,
  input wire logic [NCONN-1:0]                      tx_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NCONN-1:0] zreq;  // pending requests from access point zero
  ////////////////////////////////////////////////////////////////////////////
  // mask of priority requests
  always_comb begin
    for (int i = 0; i < NCONN; i++) begin
      zreq[i] = tx_req[i] && (conn_sapi[i] == SAPI_PRIORITY);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // first octet of a delivery
  sequence s_first;
    rx_valid && rx_first;
  endsequence
  // a new line owner appears
  sequence s_grant;
    $rose(|tx_grant);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_first_sapi: assert property (s_first |-> rx_data[7:2] == conn_sapi[rx_conn])
    else $error("first octet does not name target access point");
  a_second_tei: assert property (s_first ##1 rx_valid |-> rx_data == {conn_tei[rx_conn], 1'b1})
    else $error("second octet does not name target endpoint");
  a_burst_next: assert property (s_first |=> rx_valid && !rx_first)
    else $error("delivery not back to back");
  a_conn_hold: assert property (rx_valid && !rx_last |=> rx_valid && rx_conn == $past(rx_conn))
    else $error("target changed inside a frame");
  a_qual_valid: assert property ((rx_first || rx_last) |-> rx_valid)
    else $error("frame marker without octet");
  a_grant_one: assert property ($onehot0(tx_grant))
    else $error("more than one line owner");
  a_take_owner: assert property ((tx_take & ~tx_grant) == '0)
    else $error("octet taken from non-owner");
  a_take_pulse: assert property (|tx_take |=> tx_take == '0)
    else $error("take pulse longer than one cycle");
  a_grant_cause: assert property (s_grant |-> (tx_grant & $past(tx_req)) != '0)
    else $error("grant without request");
  a_zero_wins: assert property ($rose(|tx_grant) && $past(|zreq) |-> (tx_grant & $past(zreq)) != '0)
    else $error("access point zero lost arbitration");
  a_activate: assert property (|conn_active |=> ph_activate_req)
    else $error("no activation while connection busy");
  a_bit_hold: assert property (!tx_bit_ready |=> $stable(tx_bit))
    else $error("line bit moved without request");
endmodule

bind dchannel_frame_multiplexer dchannel_frame_multiplexer_monitor u_mon (
  .mclk(mclk), .srst(srst), .tx_bit(tx_bit), .tx_bit_ready(tx_bit_ready),
  .ph_activate_req(ph_activate_req), .conn_active(conn_active), .conn_sapi(conn_sapi),
  .conn_tei(conn_tei), .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
  .rx_last(rx_last), .rx_conn(rx_conn), .tx_req(tx_req), .tx_take(tx_take),
  .tx_grant(tx_grant)
);

//--- dlmux_phy_model.sv
module dlmux_phy_model (
  input  wire logic mclk,
  input  wire logic tx_bit,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      tx_bit_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int per = 10;  // cycles per line bit, bench may change it
  int cnt = 0;   // position inside a bit period
  bit rxq[$];    // bits waiting for the receive line
  bit txq[$];    // bits captured from the transmit line
  initial begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    tx_bit_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one strobe per bit period, on the falling edge
  always @(negedge mclk) begin
    rx_bit_valid <= (cnt == 0);
    tx_bit_ready <= (cnt == 0);
    cnt <= (cnt >= per - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      // previous requested bit has settled
      txq.push_back(tx_bit);
      if (rxq.size() == 0) begin
        for (int j = 0; j < 8; j++) rxq.push_back(dlmux_pkg::FLAG_PATTERN[j]);
      end
      rx_bit <= rxq.pop_front();
    end else begin
      // line is meaningless between strobes
      rx_bit <= ~rx_bit;
    end
  end
endmodule

//--- dchannel_frame_multiplexer_tb_top.sv
module dchannel_frame_multiplexer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dlmux_pkg::*;
  logic mclk = 1'b0, srst = 1'b1;
  logic rx_bit, rx_bit_valid, tx_bit_ready, tx_bit, ph_activate_req, rx_valid, rx_first, rx_last;
  logic [NCONN-1:0]             conn_active, tx_req, tx_octet_last, tx_take, tx_grant;
  logic [NCONN-1:0][SAPI_W-1:0] conn_sapi;
  logic [NCONN-1:0][TEI_W-1:0]  conn_tei;
  logic [NCONN-1:0][7:0]        tx_octet;
  logic [7:0]                   rx_data;
  logic [CONN_W-1:0]            rx_conn;
  int fails = 0, num_checks = 0, cyc = 0, ones = 0;
  logic [31:0] seed = 32'hc7ae1bdb;
  logic [7:0] txd[NCONN][$], rx_got[$], exp_rx[$], tx_got[$], exp_tx[$], f0[$], f1[$], f3[$];
  logic [CONN_W-1:0] conn_got[$], exp_cn[$];
  int nfr, junk;
  always #20 mclk = ~mclk;
  dchannel_frame_multiplexer u_dut (.mclk(mclk), .srst(srst), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .tx_bit_ready(tx_bit_ready), .tx_bit(tx_bit),
    .ph_activate_req(ph_activate_req), .conn_active(conn_active), .conn_sapi(conn_sapi),
    .conn_tei(conn_tei), .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_last(rx_last), .rx_conn(rx_conn), .tx_req(tx_req), .tx_octet(tx_octet),
    .tx_octet_last(tx_octet_last), .tx_take(tx_take), .tx_grant(tx_grant));
  dlmux_phy_model u_phy (.mclk(mclk), .tx_bit(tx_bit), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .tx_bit_ready(tx_bit_ready));
  ////////////////////////////////////////////////////////////////////////////
  // link procedures: present octets, move on at each take
  always @(negedge mclk) begin
    for (int i = 0; i < NCONN; i++) begin
      if (tx_take[i] === 1'b1) void'(txd[i].pop_front());
      tx_req[i] = txd[i].size() > 0;
      tx_octet[i] = tx_req[i] ? txd[i][0] : seed[7:0];
      tx_octet_last[i] = txd[i].size() == 1;
    end
  end
  // delivered octets and targets
  always @(negedge mclk) begin
    if (rx_valid === 1'b1) begin
      rx_got.push_back(rx_data);
      conn_got.push_back(rx_conn);
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // check register run lsb first, complement appended low octet first
  function automatic void add_fcs(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = FCS_PRESET;
    foreach (q[i]) for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ q[i][j]) ? FCS_POLY_REFL : 16'h0000);
    q.push_back(~c[7:0]);
    q.push_back(~c[15:8]);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic put(input logic [7:0] v, input bit stf);
    for (int j = 0; j < 8; j++) begin
      u_phy.rxq.push_back(v[j]);
      ones = v[j] ? ones + 1 : 0;
      if (stf && ones == 5) begin
        u_phy.rxq.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic load(input logic [7:0] q[$], input bit ok, input bit bad, input int cn);
    logic [7:0] f[$];
    f = q;
    add_fcs(f);
    f[f.size() - 1] ^= {7'h00, bad};
    foreach (f[i]) put(f[i], 1'b1);
    put(FLAG_PATTERN, 1'b0);
    if (ok) foreach (q[i]) begin
      exp_rx.push_back(q[i]);
      exp_cn.push_back(CONN_W'(cn));
    end
  endtask
  task automatic settle(input string nm);
    for (int k = 0; k < 9000 && u_phy.rxq.size() > 0; k++) @(negedge mclk);
    chk(16'(u_phy.rxq.size()), 16'h0000);
    repeat (60) @(negedge mclk);
    chk(16'(rx_got.size()), 16'(exp_rx.size()));
    foreach (exp_rx[i]) begin
      chk(16'(rx_got[i]), 16'(exp_rx[i]));
      chk(16'(conn_got[i]), 16'(exp_cn[i]));
    end
    rx_got.delete();
    conn_got.delete();
    exp_rx.delete();
    exp_cn.delete();
    $display("test %s done", nm);
  endtask
  // frame for one connection with a random info field
  task automatic mkf(input int c, output logic [7:0] q[$]);
    seed = lfsr(seed);
    q = '{{conn_sapi[c], 2'b00}, {conn_tei[c], 1'b1}, 8'h03};
    for (int n = 0; n < seed[1:0]; n++) q.push_back(seed[15:8] ^ 8'(n));
  endtask
  // destuff the captured transmit line into whole frames
  task automatic decode();
    int n1;
    bit sy;
    logic q[$];
    logic [7:0] v;
    nfr = 0;
    junk = 0;
    n1 = 0;
    sy = 0;
    foreach (u_phy.txq[k]) begin
      if (u_phy.txq[k]) begin
        n1++;
        q.push_back(1'b1);
      end else begin
        if (n1 == 6) begin
          if (sy && q.size() > 7) begin
            if ((q.size() - 7) % 8 != 0 || q.size() < 39) junk++;
            else nfr++;
            for (int b = 0; b < q.size() - 7; b++) begin
              v[b % 8] = q[b];
              if (b % 8 == 7) tx_got.push_back(v);
            end
          end
          sy = 1;
          q.delete();
        end else if (n1 != 5) q.push_back(1'b0);
        n1 = 0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    conn_active = '0;
    tx_req = '0;
    tx_octet = '0;
    tx_octet_last = '0;
    conn_sapi = {6'h00, 6'h10, 6'h00, 6'h05};
    conn_tei = {7'h13, 7'h12, 7'h11, 7'h10};
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    // shortest unnumbered frame, shared flag, numbered with stuffing
    load('{8'h40, 8'h25, 8'h03}, 1, 0, 2);
    load('{8'h16, 8'h21, 8'h00, 8'h02, seed[7:0], 8'hff}, 1, 0, 0);
    settle("good");
    mkf(1, f1);
    load(f1, 1, 0, 1);
    settle("random");
    // bad check, one-octet address, short numbered, unknown access point
    load('{8'h40, 8'h25, 8'h03}, 0, 1, 0);
    load('{8'h41, 8'h03, 8'h00}, 0, 0, 0);
    load('{8'h40, 8'h25, 8'h00}, 0, 0, 0);
    load('{8'h84, 8'h25, 8'h03}, 0, 0, 0);
    settle("invalid");
    put(8'h40, 1'b1);
    put(8'hff, 1'b0);
    put(FLAG_PATTERN, 1'b0);
    load('{8'h40, 8'h25, 8'h03}, 1, 0, 2);
    settle("abort");
    // three connections contend, two of them access point zero
    u_phy.per = 4;
    mkf(0, f0);
    mkf(1, f1);
    mkf(3, f3);
    u_phy.txq.delete();
    // let a whole flag reach the capture before any request
    repeat (40) @(negedge mclk);
    txd[0] = f0;
    txd[1] = f1;
    txd[3] = f3;
    conn_active = 4'hb;
    repeat (3) @(negedge mclk);
    chk(16'(ph_activate_req), 16'h0001);
    for (int k = 0; k < 9000 && (tx_req != '0 || tx_grant != '0); k++) @(negedge mclk);
    chk(16'(tx_req), 16'h0000);
    repeat (200) @(negedge mclk);
    conn_active = '0;
    add_fcs(f0);
    add_fcs(f1);
    add_fcs(f3);
    exp_tx = {f1, f3, f0};
    decode();
    chk(16'(nfr), 16'h0003);
    chk(16'(junk), 16'h0000);
    chk(16'(tx_got.size()), 16'(exp_tx.size()));
    foreach (exp_tx[i]) chk(16'(tx_got[i]), 16'(exp_tx[i]));
    repeat (4) @(negedge mclk);
    chk(16'(ph_activate_req), 16'h0000);
    $display("test transmit done");
    end_sim();
  end
endmodule
